// ===== hw/ptp_port_capture.sv
// Capture qualifier for one switch port: address match, role filter and capture lock.
`timescale 1ns/10ps
`default_nettype none
module ptp_port_capture
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [ptp_cfg_pkg::PORT_FIELDS-1:0] port_fields,
   input wire logic [ptp_cfg_pkg::MAC_W-1:0] aux_addr,
   input wire logic frame_valid,
   input wire logic frame_tx,
   input wire logic [3:0] msg_type,
   input wire logic [ptp_cfg_pkg::MAC_W-1:0] dest_addr,
   input wire logic irq_rx_pending,
   input wire logic irq_tx_pending,
   output logic capture_rx_q,
   output logic capture_tx_q
);
   import ptp_cfg_pkg::*;

   logic [FIXED_ADDRS-1:0] fixed_hit;
   logic aux_hit;
   logic addr_hit;
   logic want_tx;
   logic want_rx;
   logic qual_tx;
   logic qual_rx;
   logic capture_rx_d;
   logic capture_tx_d;

   // ****************************************************************
   // Address recognition
   // ****************************************************************
   // fixed address enables
   for (genvar i = 0; i < FIXED_ADDRS; i++)
   begin : g_fixed
      assign fixed_hit[i] = port_fields[FLD_PRI - i] && (dest_addr == PTP_ADDRS[i]);
   end

   always_comb
   begin
      aux_hit = port_fields[FLD_AUX] && (dest_addr == aux_addr);
      addr_hit = (|fixed_hit) || aux_hit;
      want_tx = port_fields[FLD_ROLE] ? (msg_type == MSG_SYNC) : (msg_type == MSG_DELAY_REQ);
      want_rx = port_fields[FLD_ROLE] ? (msg_type == MSG_DELAY_REQ) : (msg_type == MSG_SYNC);
      qual_tx = frame_valid && frame_tx && addr_hit && want_tx;
      qual_rx = frame_valid && !frame_tx && addr_hit && want_rx;
      capture_tx_d = qual_tx && !(port_fields[FLD_LOCK_TX] && irq_tx_pending);
      capture_rx_d = qual_rx && !(port_fields[FLD_LOCK_RX] && irq_rx_pending);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         capture_rx_q <= 1'b0;
         capture_tx_q <= 1'b0;
      end
      else
      begin
         capture_rx_q <= capture_rx_d;
         capture_tx_q <= capture_tx_d;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_MASTER_TX_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid && frame_tx && addr_hit && port_fields[FLD_ROLE] && msg_type == MSG_SYNC
      && !(port_fields[FLD_LOCK_TX] && irq_tx_pending) |=> capture_tx_q)
      else $error("Master did not capture transmitted Sync.");
   AST_SLAVE_RX_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid && !frame_tx && addr_hit && !port_fields[FLD_ROLE] && msg_type == MSG_SYNC
      && !(port_fields[FLD_LOCK_RX] && irq_rx_pending) |=> capture_rx_q)
      else $error("Slave did not capture received Sync.");
   AST_ROLE_FILTER: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid && frame_tx && port_fields[FLD_ROLE] && msg_type == MSG_DELAY_REQ |=> !capture_tx_q)
      else $error("Master captured transmitted Delay_Req.");
   AST_NO_ADDR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid && !addr_hit |=> !capture_tx_q && !capture_rx_q)
      else $error("Capture without enabled address match.");
   AST_PRI_HIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      dest_addr == PTP_ADDRS[0] && port_fields[FLD_PRI] |-> addr_hit)
      else $error("Enabled primary address not recognised.");
   AST_AUX_HIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
      dest_addr == aux_addr && port_fields[FLD_AUX] |-> addr_hit)
      else $error("Enabled auxiliary address not recognised.");
   AST_LOCK_RX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      port_fields[FLD_LOCK_RX] && irq_rx_pending |=> !capture_rx_q)
      else $error("Receive capture overwrote a locked entry.");
   AST_UNLOCKED_TX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      qual_tx && !port_fields[FLD_LOCK_TX] && irq_tx_pending |=> capture_tx_q)
      else $error("Unlocked transmit capture was held off.");
   COV_LOCKED: cover property (@(posedge sys_clk) disable iff (!reset_n)
      qual_rx && port_fields[FLD_LOCK_RX] && irq_rx_pending);
   COV_TX_CAPTURE: cover property (@(posedge sys_clk) disable iff (!reset_n) capture_tx_q);
endmodule
`default_nettype wire

// ===== hw/ptp_port_timestamp_config.sv
// Timestamp port configuration register with the capture qualifiers for ports 1 and 2.
`timescale 1ns/10ps
`default_nettype none
module ptp_port_timestamp_config
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [ptp_cfg_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ptp_cfg_pkg::DATA_W-1:0] reg_wdata,
   output logic [ptp_cfg_pkg::DATA_W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   input wire logic [ptp_cfg_pkg::AUX_HI_W-1:0] aux_ptp_addr_high,
   input wire logic [ptp_cfg_pkg::AUX_LO_W-1:0] aux_ptp_addr_low,
   input wire logic [1:0] frame_valid,
   input wire logic [1:0] frame_tx,
   input wire logic [1:0][3:0] msg_type,
   input wire logic [1:0][ptp_cfg_pkg::MAC_W-1:0] dest_addr,
   input wire logic [1:0] irq_rx_pending,
   input wire logic [1:0] irq_tx_pending,
   output logic [1:0] capture_rx_q,
   output logic [1:0] capture_tx_q
);
   import ptp_cfg_pkg::*;

   logic [DATA_W-1:0] cfg_q;
   logic [DATA_W-1:0] cfg_d;
   logic [DATA_W-1:0] reg_rdata_d;
   logic reg_rvalid_d;
   logic [MAC_W-1:0] aux_addr;
   logic cfg_sel;

   // ****************************************************************
   // Register access
   // ****************************************************************
   // A read in the same cycle as a write returns the old contents, so software sees
   // a stable value and never half of an update.
   always_comb
   begin
      cfg_sel = (reg_addr == CFG_OFFSET);
      cfg_d = cfg_q;
      if (reg_wr && cfg_sel)
      begin
         cfg_d = reg_wdata;
      end
      reg_rvalid_d = reg_rd;
      reg_rdata_d = '0;
      if (reg_rd && cfg_sel)
      begin
         reg_rdata_d = cfg_q;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         cfg_q <= CFG_RESET;
         reg_rdata_q <= '0;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         reg_rdata_q <= reg_rdata_d;
         reg_rvalid_q <= reg_rvalid_d;
      end
   end

   // ****************************************************************
   // Per-port capture qualifiers, index 0 is port 1, index 1 is port 2
   // ****************************************************************
   // auxiliary address join
   assign aux_addr = {aux_ptp_addr_high, aux_ptp_addr_low};

   // The low port 1 fields and the port 0 fields are stored and read back, but their
   // qualifiers live elsewhere; only the group at each base feeds this block.
   for (genvar g = 0; g < 2; g++)
   begin : g_port
      localparam int BASE = (g == 0) ? P1_BASE : P2_BASE;
      ptp_port_capture u_capture
      (
         .sys_clk(sys_clk),
         .reset_n(reset_n),
         .port_fields(cfg_q[BASE -: PORT_FIELDS]),
         .aux_addr(aux_addr),
         .frame_valid(frame_valid[g]),
         .frame_tx(frame_tx[g]),
         .msg_type(msg_type[g]),
         .dest_addr(dest_addr[g]),
         .irq_rx_pending(irq_rx_pending[g]),
         .irq_tx_pending(irq_tx_pending[g]),
         .capture_rx_q(capture_rx_q[g]),
         .capture_tx_q(capture_tx_q[g])
      );
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_RESET_DEFAULT: assert property (@(posedge sys_clk)
      !reset_n |=> cfg_q == CFG_RESET && !reg_rvalid_q)
      else $error("Register did not take its default on reset.");
   AST_WRITE_TAKES: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == CFG_OFFSET |=> cfg_q == $past(reg_wdata))
      else $error("Write to the configuration register was lost.");
   AST_WRITE_THEN_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == CFG_OFFSET ##1 reg_rd && reg_addr == CFG_OFFSET && !reg_wr
      |=> reg_rvalid_q && reg_rdata_q == $past(reg_wdata, 2))
      else $error("Readback differs from the value written.");
   AST_OTHER_ADDR: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr != CFG_OFFSET |=> $stable(cfg_q))
      else $error("Write to another address changed the register.");
   AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      reg_rd && reg_addr != CFG_OFFSET |=> reg_rvalid_q && reg_rdata_q == '0)
      else $error("Unmapped read returned nonzero data.");
   AST_P2_LOCK_TX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cfg_q[P2_BASE - FLD_ROLE + FLD_LOCK_TX] && irq_tx_pending[1] |=> !capture_tx_q[1])
      else $error("Port 2 transmit capture overwrote a locked entry.");
   AST_P1_PRI_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && dest_addr[0] == PTP_ADDRS[0] && cfg_q[P1_BASE - FLD_ROLE + FLD_PRI : P1_BASE - 6] == '0
      |=> !capture_rx_q[0] && !capture_tx_q[0])
      else $error("Port 1 captured a disabled primary address.");
   AST_P2_ALT1: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[1] && cfg_q[29] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 missed a Sync on the first alternate address.");

   // ****************************************************************
   // Per-field checks
   // ****************************************************************
   // Each port 2 enable and the port 1 primary and first two alternate enables are checked alone with the lock out of the way, so a swapped field
   // position shows up as a missed capture rather than hiding behind another enable.
   AST_P2_ALT2: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[2] && cfg_q[28] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 missed a Sync on the second alternate address.");
   AST_P2_ALT3: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[3] && cfg_q[27] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 missed a Sync on the third alternate address.");
   AST_P2_AUX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == aux_addr && cfg_q[26] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 missed a Sync on the auxiliary address.");
   AST_P2_PRI_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[0] && cfg_q[30] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 missed a Sync on the primary address.");
   AST_P2_SLAVE_TX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && frame_tx[1] && dest_addr[1] == PTP_ADDRS[0] && cfg_q[30] && !cfg_q[31]
      && msg_type[1] == MSG_DELAY_REQ && !(cfg_q[24] && irq_tx_pending[1]) |=> capture_tx_q[1])
      else $error("Port 2 slave missed a transmitted Delay_Req.");
   AST_P2_MASTER_RX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[1] && cfg_q[29] && cfg_q[31]
      && msg_type[1] == MSG_DELAY_REQ && !(cfg_q[25] && irq_rx_pending[1]) |=> capture_rx_q[1])
      else $error("Port 2 master missed a received Delay_Req.");
   AST_P2_LOCK_RX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      cfg_q[25] && irq_rx_pending[1] |=> !capture_rx_q[1])
      else $error("Port 2 receive capture overwrote a locked entry.");
   AST_P2_UNLOCKED_RX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[1] && !frame_tx[1] && dest_addr[1] == PTP_ADDRS[0] && cfg_q[30] && !cfg_q[31]
      && msg_type[1] == MSG_SYNC && !cfg_q[25] |=> capture_rx_q[1])
      else $error("Port 2 unlocked receive capture was held off.");
   AST_P1_PRI_ON: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && !frame_tx[0] && dest_addr[0] == PTP_ADDRS[0] && cfg_q[22] && !cfg_q[23]
      && msg_type[0] == MSG_SYNC && !(cfg_q[17] && irq_rx_pending[0]) |=> capture_rx_q[0])
      else $error("Port 1 missed a Sync on the primary address.");
   AST_P1_ALT1: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && !frame_tx[0] && dest_addr[0] == PTP_ADDRS[1] && cfg_q[21] && !cfg_q[23]
      && msg_type[0] == MSG_SYNC && !(cfg_q[17] && irq_rx_pending[0]) |=> capture_rx_q[0])
      else $error("Port 1 missed a Sync on the first alternate address.");
   AST_P1_ALT2: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && !frame_tx[0] && dest_addr[0] == PTP_ADDRS[2] && cfg_q[20] && !cfg_q[23]
      && msg_type[0] == MSG_SYNC && !(cfg_q[17] && irq_rx_pending[0]) |=> capture_rx_q[0])
      else $error("Port 1 missed a Sync on the second alternate address.");
   AST_P1_MASTER_TX: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && frame_tx[0] && dest_addr[0] == PTP_ADDRS[1] && cfg_q[21] && cfg_q[23]
      && msg_type[0] == MSG_SYNC && !(cfg_q[16] && irq_tx_pending[0]) |=> capture_tx_q[0])
      else $error("Port 1 master missed a transmitted Sync.");
   AST_P1_SLAVE_TX_SYNC: assert property (@(posedge sys_clk) disable iff (!reset_n)
      frame_valid[0] && frame_tx[0] && !cfg_q[23] && msg_type[0] == MSG_SYNC |=> !capture_tx_q[0])
      else $error("Port 1 slave captured a transmitted Sync.");
   AST_RVALID_ONLY_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !reg_rd |=> !reg_rvalid_q)
      else $error("Read valid without a read.");
   AST_IDLE_RDATA: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !reg_rd |=> reg_rdata_q == '0)
      else $error("Read data not zero outside a read.");
   COV_CFG_WRITE: cover property (@(posedge sys_clk) disable iff (!reset_n)
      reg_wr && reg_addr == CFG_OFFSET);
   COV_P2_MASTER: cover property (@(posedge sys_clk) disable iff (!reset_n)
      cfg_q[P2_BASE] && capture_tx_q[1]);
   COV_P1_SLAVE_RX: cover property (@(posedge sys_clk) disable iff (!reset_n)
      !cfg_q[P1_BASE] && capture_rx_q[0]);
endmodule
`default_nettype wire

// ===== pkg/ptp_cfg_pkg.sv
// Shared constants for the timestamp port configuration register and its capture qualifiers.
package ptp_cfg_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam logic [8:0] CFG_OFFSET = 9'h194;
   localparam logic [31:0] CFG_RESET = 32'h4343_4000;

   // ****************************************************************
   // Per-port field groups, eight bits each, top bit is the role
   // ****************************************************************
   localparam int PORT_FIELDS = 8;
   localparam int P1_BASE = 23;
   localparam int P2_BASE = 31;
   localparam int FLD_ROLE = 7;
   localparam int FLD_PRI = 6;
   localparam int FLD_AUX = 2;
   localparam int FLD_LOCK_RX = 1;
   localparam int FLD_LOCK_TX = 0;

   // ****************************************************************
   // Addresses and message types
   // ****************************************************************
   localparam int MAC_W = 48;
   localparam int AUX_HI_W = 16;
   localparam int AUX_LO_W = 32;
   localparam int FIXED_ADDRS = 4;
   // Entry 0 is the primary address, entries 1 to 3 the alternates.
   localparam logic [3:0][47:0] PTP_ADDRS = {48'h01005e000184, 48'h01005e000183,
                                             48'h01005e000182, 48'h01005e000181};
   localparam logic [3:0] MSG_SYNC = 4'h0;
   localparam logic [3:0] MSG_DELAY_REQ = 4'h1;

endpackage

// ===== tb/reg_sw_model.sv
// Software model that reaches the configuration register through its word-wide bus.
`timescale 1ns/10ps
`default_nettype none
module reg_sw_model
(
   input wire logic sys_clk,
   output logic [ptp_cfg_pkg::ADDR_W-1:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [ptp_cfg_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [ptp_cfg_pkg::DATA_W-1:0] reg_rdata_q,
   input wire logic reg_rvalid_q
);
   import ptp_cfg_pkg::*;
   initial
   begin
      reg_addr = 9'h000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   // Released data is inverted so a stale value is never mistaken for a held one.
   // whole word write
   task automatic write_word(input logic [8:0] addr, input logic [31:0] data);
      @(posedge sys_clk);
      #1;
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~data;
   endtask
   // write then read back to back
   task automatic write_read(input logic [8:0] addr, input logic [31:0] data, output logic [31:0] rdata,
      output logic vld);
      @(posedge sys_clk);
      #1;
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~data;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      rdata = reg_rdata_q;
      vld = reg_rvalid_q;
   endtask
   task automatic read_word(input logic [8:0] addr, output logic [31:0] data, output logic vld);
      @(posedge sys_clk);
      #1;
      reg_addr = addr;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~addr;
      data = reg_rdata_q;
      vld = reg_rvalid_q;
   endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the timestamp port configuration register and its capture qualifiers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb;
   import ptp_cfg_pkg::*;
   typedef struct packed {logic [31:0] cfg; logic p; logic tx; logic [3:0] msg; logic [2:0] sel;
      logic irq; logic [1:0] exp;} row_t;
   localparam logic [47:0] AUX = 48'h1234_5678_9abc;
   localparam row_t ROWS[21] = '{
      '{32'h4343_4000, 1, 0, 0, 0, 0, 2'b10},
      '{32'h4343_4000, 0, 0, 0, 0, 0, 2'b10},
      '{32'h4343_4000, 1, 1, 0, 0, 0, 2'b00},
      '{32'h4343_4000, 1, 1, 1, 0, 0, 2'b01},
      '{32'h4343_4000, 1, 0, 0, 1, 0, 2'b00},
      '{32'h4343_4000, 1, 0, 0, 0, 1, 2'b00},
      '{32'h4343_4000, 1, 1, 1, 0, 1, 2'b00},
      '{32'h4343_4000, 1, 0, 2, 0, 0, 2'b00},
      '{32'ha000_0000, 1, 1, 0, 1, 0, 2'b01},
      '{32'ha000_0000, 1, 0, 1, 1, 0, 2'b10},
      '{32'ha000_0000, 1, 0, 1, 0, 0, 2'b00},
      '{32'h1010_0000, 1, 0, 0, 2, 0, 2'b10},
      '{32'h1010_0000, 0, 0, 0, 2, 0, 2'b10},
      '{32'h1010_0000, 0, 0, 0, 0, 0, 2'b00},
      '{32'h08a0_0000, 1, 0, 0, 3, 0, 2'b10},
      '{32'h08a0_0000, 0, 1, 0, 1, 0, 2'b01},
      '{32'h08a0_0000, 0, 0, 0, 1, 0, 2'b00},
      '{32'h0400_0000, 1, 0, 0, 4, 0, 2'b10},
      '{32'h0400_0000, 1, 0, 0, 5, 0, 2'b00},
      '{32'h4000_0000, 1, 0, 0, 0, 1, 2'b10},
      '{32'h4000_0000, 1, 1, 1, 0, 1, 2'b01}};
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [8:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata_q;
   logic reg_rvalid_q;
   logic [1:0] frame_valid = 2'b00;
   logic [1:0] frame_tx = 2'b00;
   logic [1:0][3:0] msg_type = '0;
   logic [1:0][47:0] dest_addr = '0;
   logic [1:0] irq_rx_pending = 2'b00;
   logic [1:0] irq_tx_pending = 2'b00;
   logic [1:0] capture_rx_q;
   logic [1:0] capture_tx_q;
   logic [31:0] rd;
   logic vld;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #5 sys_clk = ~sys_clk;
   ptp_port_timestamp_config u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q), .aux_ptp_addr_high(AUX[47:32]), .aux_ptp_addr_low(AUX[31:0]),
      .frame_valid(frame_valid), .frame_tx(frame_tx), .msg_type(msg_type), .dest_addr(dest_addr),
      .irq_rx_pending(irq_rx_pending), .irq_tx_pending(irq_tx_pending),
      .capture_rx_q(capture_rx_q), .capture_tx_q(capture_tx_q));
   reg_sw_model u_sw (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic send_frame(input row_t r);
      @(posedge sys_clk);
      #1;
      frame_valid[r.p] = 1'b1;
      frame_tx[r.p] = r.tx;
      msg_type[r.p] = r.msg;
      dest_addr[r.p] = (r.sel < 4) ? PTP_ADDRS[r.sel[1:0]] : (r.sel == 4) ? AUX : 48'h0100_5e00_0185;
      irq_rx_pending[r.p] = r.irq;
      irq_tx_pending[r.p] = r.irq;
      @(posedge sys_clk);
      #1;
      frame_valid = 2'b00;
      irq_rx_pending = 2'b00;
      irq_tx_pending = 2'b00;
      `CHK({capture_rx_q[r.p], capture_tx_q[r.p]}, r.exp)
      `CHK({capture_rx_q[~r.p], capture_tx_q[~r.p]}, 2'b00)
   endtask
   // A hang is cut short well above the hundred or so cycles the run needs.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      for (int i = 0; i < 21; i++)
      begin
         u_sw.write_word(CFG_OFFSET, ROWS[i].cfg);
         send_frame(ROWS[i]);
      end
      u_sw.write_read(CFG_OFFSET, 32'h5a5a_a5a5, rd, vld);
      `CHK({vld, rd}, {1'b1, 32'h5a5a_a5a5})
      u_sw.write_word(9'h190, 32'hffff_ffff);
      u_sw.read_word(9'h190, rd, vld);
      `CHK({vld, rd}, {1'b1, 32'h0000_0000})
      u_sw.read_word(CFG_OFFSET, rd, vld);
      `CHK(rd, 32'h5a5a_a5a5)
      // A second reset in mid-run must bring back every documented default.
      reset_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      u_sw.read_word(CFG_OFFSET, rd, vld);
      `CHK(rd, CFG_RESET)
      print_verdict();
   end
endmodule
`default_nettype wire
